// ===== rtl/sync_recovery.sv
// Encoder front end: sync recovery, timing code decode and pixel FIFO
`default_nettype none
module vid_fifo
    import vsync_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             out_valid_r;
    logic             out_valid_nxt;
    logic [WIDTH-1:0] out_data_r;
    logic [WIDTH-1:0] out_data_nxt;
    logic             push;
    logic             load;

    assign in_ready_out  = count_r != DEPTH[AW:0];
    assign out_valid_out = out_valid_r;
    assign out_data_out  = out_data_r;

    // Output stage is a register so the consumer never sees a memory mux
    always_comb
    begin
        push          = in_valid_in && in_ready_out;
        load          = (count_r != '0) && (!out_valid_r || out_ready_in);
        wr_ptr_nxt    = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt    = load ? rd_ptr_r + 1'b1 : rd_ptr_r;
        count_nxt     = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        out_valid_nxt = load ? 1'b1 : (out_ready_in ? 1'b0 : out_valid_r);
        out_data_nxt  = load ? mem_r[rd_ptr_r] : out_data_r;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            count_r     <= '0;
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end
        else
        begin
            wr_ptr_r    <= wr_ptr_nxt;
            rd_ptr_r    <= rd_ptr_nxt;
            count_r     <= count_nxt;
            out_valid_r <= out_valid_nxt;
            out_data_r  <= out_data_nxt;
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data_in;
    end
endmodule : vid_fifo

module sync_recovery
    import vsync_pkg::*;
(
    input  wire logic        SYS_CLK_IN,
    input  wire logic        NRST_IN,
    vid_link_if.encoder      LINK,
    input  wire logic        EMBEDDED_SYNC_SELECT_IN,
    input  wire logic        STD_625_IN,
    input  wire logic        SQUARE_PIXEL_IN,
    input  wire logic        VIDEO_READY_IN,
    output logic       [7:0] VIDEO_DATA_OUT,
    output logic             VIDEO_VALID_OUT,
    output logic             FIELD2_OUT,
    output logic             VBLANK_OUT,
    output logic       [9:0] LINE_OUT,
    output logic             EAV_OUT,
    output logic             SAV_OUT,
    output logic             LOCKED_OUT,
    output logic             MODE_ERR_OUT,
    output logic             OVERFLOW_OUT
);
    typedef enum logic [1:0] {HUNT_IDLE, HUNT_FF, HUNT_00A, HUNT_00B} pre_state_e;

    pre_state_e  pre_r;
    pre_state_e  pre_nxt;
    logic        trc_hit;
    logic [7:0]  code;
    logic        hs_prev_r;
    logic        vs_prev_r;
    logic [10:0] pix_r;
    logic [10:0] pix_nxt;
    logic [9:0]  line_r;
    logic [9:0]  line_nxt;
    logic        field2_r;
    logic        field2_nxt;
    logic        vblank_r;
    logic        vblank_nxt;
    logic [2:0]  age_r;
    logic [2:0]  age_nxt;
    logic        cand_r;
    logic        cand_nxt;
    logic        locked_r;
    logic        locked_nxt;
    logic        eav_r;
    logic        eav_nxt;
    logic        sav_r;
    logic        sav_nxt;
    logic        err_r;
    logic        ovf_r;
    logic        ovf_nxt;
    logic        wr_valid_r;
    logic        wr_valid_nxt;
    logic [7:0]  wr_data_r;
    logic        fifo_ready;
    logic        emb;
    logic        hs_fall;
    logic        hs_rise;
    logic        vs_fall;
    logic        step;
    logic        active;
    logic [10:0] cb0;

    // Preamble hunt; any word that breaks the sequence starts it over
    always_comb
    begin
        pre_nxt = HUNT_IDLE;
        trc_hit = 1'b0;
        code    = LINK.pixel_data;
        case (pre_r)
            HUNT_FF:  pre_nxt = (code == PRE_00) ? HUNT_00A : ((code == PRE_FF) ? HUNT_FF : HUNT_IDLE);
            HUNT_00A: pre_nxt = (code == PRE_00) ? HUNT_00B : ((code == PRE_FF) ? HUNT_FF : HUNT_IDLE);
            HUNT_00B:
            begin
                trc_hit = code[FIXED_BIT];
                pre_nxt = (code == PRE_FF) ? HUNT_FF : HUNT_IDLE;
            end
            HUNT_IDLE: pre_nxt = (code == PRE_FF) ? HUNT_FF : HUNT_IDLE;
            default:   pre_nxt = HUNT_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
            pre_r <= HUNT_IDLE;
        else
            pre_r <= pre_nxt;
    end

    // Line timing; counters keep running when syncs vanish
    always_comb
    begin
        emb        = EMBEDDED_SYNC_SELECT_IN && !SQUARE_PIXEL_IN;
        hs_fall    = hs_prev_r && !LINK.line_sync_n;
        hs_rise    = !hs_prev_r && LINK.line_sync_n;
        vs_fall    = vs_prev_r && !LINK.frame_sync_n;
        pix_nxt    = (pix_r == line_words(STD_625_IN) - 11'd1) ? 11'd0 : pix_r + 11'd1;
        line_nxt   = line_r;
        field2_nxt = field2_r;
        vblank_nxt = vblank_r;
        locked_nxt = locked_r;
        eav_nxt    = 1'b0;
        sav_nxt    = 1'b0;
        cand_nxt   = cand_r;
        age_nxt    = vs_fall ? 3'd0 : ((age_r == AGE_MAX) ? AGE_MAX : age_r + 3'd1);
        step       = 1'b0;
        if (emb)
        begin
            // No free-run before the first code: an unaligned step would skew the line count
            step = locked_r && (pix_nxt == EAV_CODE);
            if (trc_hit && code[H_BIT])
            begin
                pix_nxt    = EAV_CODE;
                step       = 1'b1;
                eav_nxt    = 1'b1;
                locked_nxt = 1'b1;
                field2_nxt = code[F_BIT];
                vblank_nxt = code[V_BIT];
            end
            else if (trc_hit)
                sav_nxt = 1'b1;
        end
        else
        begin
            if (hs_fall)
                pix_nxt = 11'd0;
            step = pix_nxt == 11'd0;
        end
        if (step)
            line_nxt = (line_r >= line_total(STD_625_IN)) ? 10'd1 : line_r + 10'd1;
        if (emb && eav_nxt && field2_r && !code[F_BIT])
            line_nxt = first_line(STD_625_IN);
        if (!emb)
        begin
            if (hs_fall)
                cand_nxt = age_nxt <= SYNC_WIN;
            if (vs_fall && !LINK.line_sync_n && !hs_fall)
                cand_nxt = 1'b1;
            if (hs_rise)
            begin
                cand_nxt = 1'b0;
                if (cand_r && age_nxt >= SYNC_WIN && !(locked_r && field2_r))
                begin
                    line_nxt   = first_line(STD_625_IN);
                    locked_nxt = 1'b1;
                end
            end
            field2_nxt = is_field2(STD_625_IN, line_nxt);
            vblank_nxt = is_vblank(STD_625_IN, line_nxt);
        end
        cb0    = STD_625_IN ? CB0_625 : CB0_525;
        active = emb ? (pix_nxt < ACTIVE_WORDS)
                     : ((pix_nxt >= cb0) && (pix_nxt < cb0 + ACTIVE_WORDS));
        wr_valid_nxt = active && !vblank_nxt
                       && !(STD_625_IN && (line_nxt == DROP_LINE_A || line_nxt == DROP_LINE_B));
        ovf_nxt = ovf_r || (wr_valid_r && !fifo_ready);
    end

    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            hs_prev_r  <= 1'b1;
            vs_prev_r  <= 1'b1;
            pix_r      <= '0;
            line_r     <= 10'd1;
            field2_r   <= 1'b0;
            vblank_r   <= 1'b1;
            age_r      <= AGE_MAX;
            cand_r     <= 1'b0;
            locked_r   <= 1'b0;
            eav_r      <= 1'b0;
            sav_r      <= 1'b0;
            err_r      <= 1'b0;
            ovf_r      <= 1'b0;
            wr_valid_r <= 1'b0;
            wr_data_r  <= '0;
        end
        else
        begin
            hs_prev_r  <= LINK.line_sync_n;
            vs_prev_r  <= LINK.frame_sync_n;
            pix_r      <= pix_nxt;
            line_r     <= line_nxt;
            field2_r   <= field2_nxt;
            vblank_r   <= vblank_nxt;
            age_r      <= age_nxt;
            cand_r     <= cand_nxt;
            locked_r   <= locked_nxt;
            eav_r      <= eav_nxt;
            sav_r      <= sav_nxt;
            err_r      <= EMBEDDED_SYNC_SELECT_IN && SQUARE_PIXEL_IN;
            ovf_r      <= ovf_nxt;
            wr_valid_r <= wr_valid_nxt;
            wr_data_r  <= LINK.pixel_data;
        end
    end

    // A video stream cannot be paused, so a full FIFO drops words and flags it
    vid_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (SYS_CLK_IN),
        .rst_n_in      (NRST_IN),
        .in_valid_in   (wr_valid_r),
        .in_data_in    (wr_data_r),
        .in_ready_out  (fifo_ready),
        .out_valid_out (VIDEO_VALID_OUT),
        .out_data_out  (VIDEO_DATA_OUT),
        .out_ready_in  (VIDEO_READY_IN)
    );

    assign FIELD2_OUT   = field2_r;
    assign VBLANK_OUT   = vblank_r;
    assign LINE_OUT     = line_r;
    assign EAV_OUT      = eav_r;
    assign SAV_OUT      = sav_r;
    assign LOCKED_OUT   = locked_r;
    assign MODE_ERR_OUT = err_r;
    assign OVERFLOW_OUT = ovf_r;
endmodule : sync_recovery
`default_nettype wire

// ===== shared/vsync_pkg.sv
// Shared constants and helpers for the video sync recovery link
//
// Contract
// - 525: frame fall within line-4 strobe window
// - 525: frame rise free, low about 3 lines
// - 625: frame fall within line-1 strobe window
// - 625: frame rise free, low 2-3 lines
// - Frame strobe honoured in first field only
// - 525 lines per frame, 480 active
// - 625 lines per frame in strobe mode
// - 625: drop pixel data of line 23
// - 625: drop pixel data of line 623
// - Embedded mode times lines from end code
// - No embedded mode at square-pixel rate
// - Preamble ff 00 00 precedes timing code
// - Code bits: 1, field, vblank, start/end, protection
// - Vertical flag 1 means field blanking
// - Start/end flag 0 start, 1 end
// - Select bit: 0 strobes, 1 embedded codes
// - Free-run on last valid timing
// - Sample where line strobe falls is pixel zero
`default_nettype none
package vsync_pkg;
    localparam logic [9:0]  LINES_525        = 10'd525;
    localparam logic [9:0]  LINES_625        = 10'd625;
    localparam logic [9:0]  ACTIVE_LINES_525 = 10'd480;
    localparam logic [9:0]  ACTIVE_LINES_625 = 10'd576;
    localparam logic [9:0]  ACTIVE_FIRST     = 10'd23;
    localparam logic [9:0]  F2_ACTIVE_525    = 10'd286;
    localparam logic [9:0]  F2_ACTIVE_625    = 10'd336;
    localparam logic [9:0]  FIRST_LINE_525   = 10'd4;
    localparam logic [9:0]  FIRST_LINE_625   = 10'd1;
    localparam logic [9:0]  FIELD2_LINE_525  = 10'd266;
    localparam logic [9:0]  FIELD2_LINE_625  = 10'd313;
    localparam logic [9:0]  DROP_LINE_A      = 10'd23;
    localparam logic [9:0]  DROP_LINE_B      = 10'd623;
    localparam logic [9:0]  VS_LOW_LINES     = 10'd3;
    localparam logic [10:0] WORDS_525        = 11'd1716;
    localparam logic [10:0] WORDS_625        = 11'd1728;
    localparam logic [10:0] ACTIVE_WORDS     = 11'd1440;
    localparam logic [10:0] EAV_FIRST        = 11'd1440;
    localparam logic [10:0] EAV_CODE         = 11'd1443;
    localparam logic [10:0] CB0_525          = 11'd244;
    localparam logic [10:0] CB0_625          = 11'd264;
    localparam logic [10:0] HS_LOW_WORDS     = 11'd128;
    localparam logic [2:0]  SYNC_WIN         = 3'd3;
    localparam logic [2:0]  AGE_MAX          = 3'd7;
    localparam logic [7:0]  PRE_FF           = 8'hff;
    localparam logic [7:0]  PRE_00           = 8'h00;
    localparam logic [7:0]  BLANK_C          = 8'h80;
    localparam logic [7:0]  BLANK_Y          = 8'h10;
    localparam int          FIXED_BIT        = 7;
    localparam int          F_BIT            = 6;
    localparam int          V_BIT            = 5;
    localparam int          H_BIT            = 4;
    localparam int          FIFO_WIDTH       = 8;
    localparam int          FIFO_DEPTH       = 32;

    function automatic logic [9:0] line_total(input logic std625);
        line_total = std625 ? LINES_625 : LINES_525;
    endfunction : line_total

    function automatic logic [10:0] line_words(input logic std625);
        line_words = std625 ? WORDS_625 : WORDS_525;
    endfunction : line_words

    function automatic logic [9:0] first_line(input logic std625);
        first_line = std625 ? FIRST_LINE_625 : FIRST_LINE_525;
    endfunction : first_line

    function automatic logic is_field2(input logic std625, input logic [9:0] line);
        if (std625)
            is_field2 = line >= FIELD2_LINE_625;
        else
            is_field2 = (line >= FIELD2_LINE_525) || (line < FIRST_LINE_525);
    endfunction : is_field2

    // Half of the active lines sit in each field
    function automatic logic is_vblank(input logic std625, input logic [9:0] line);
        logic [9:0] half;
        logic [9:0] f2;
        half = std625 ? (ACTIVE_LINES_625 >> 1) : (ACTIVE_LINES_525 >> 1);
        f2 = std625 ? F2_ACTIVE_625 : F2_ACTIVE_525;
        is_vblank = (line < ACTIVE_FIRST) || ((line >= ACTIVE_FIRST + half) && (line < f2))
                    || (line >= f2 + half);
    endfunction : is_vblank

    function automatic logic [7:0] trc_word(input logic f, input logic v, input logic h);
        trc_word = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction : trc_word
endpackage : vsync_pkg
`default_nettype wire

// ===== shared/vid_link_if.sv
// Pixel link between the video source and the encoder front end
`default_nettype none
interface vid_link_if;
    logic [7:0] pixel_data;
    logic       line_sync_n;
    logic       frame_sync_n;
    modport source  (output pixel_data, line_sync_n, frame_sync_n);
    modport encoder (input  pixel_data, line_sync_n, frame_sync_n);
endinterface : vid_link_if
`default_nettype wire

// ===== rtl/video_source.sv
// Video source end: drives pixel data with strobes or embedded timing codes
`default_nettype none
module video_source
    import vsync_pkg::*;
(
    input  wire logic       SYS_CLK_IN,
    input  wire logic       NRST_IN,
    vid_link_if.source      LINK,
    input  wire logic       EMBEDDED_SYNC_SELECT_IN,
    input  wire logic       STD_625_IN,
    input  wire logic       SQUARE_PIXEL_IN,
    input  wire logic [7:0] PIX_DATA_IN,
    output logic            PIX_TAKE_OUT
);
    logic [10:0] pix_r;
    logic [10:0] pix_nxt;
    logic [9:0]  line_r;
    logic [9:0]  line_nxt;
    logic [9:0]  next_line;
    logic [7:0]  data_r;
    logic [7:0]  data_nxt;
    logic        hs_n_r;
    logic        hs_n_nxt;
    logic        vs_n_r;
    logic        vs_n_nxt;
    logic        take_r;
    logic        take_nxt;
    logic        emb;
    logic        f;
    logic        v;
    logic [10:0] sav_first;
    logic [10:0] cb0;
    logic [9:0]  first;

    always_comb
    begin
        emb       = EMBEDDED_SYNC_SELECT_IN && !SQUARE_PIXEL_IN;
        pix_nxt   = (pix_r == line_words(STD_625_IN) - 11'd1) ? 11'd0 : pix_r + 11'd1;
        line_nxt  = line_r;
        if (pix_nxt == 11'd0)
            line_nxt = (line_r >= line_total(STD_625_IN)) ? 10'd1 : line_r + 10'd1;
        next_line = (line_nxt >= line_total(STD_625_IN)) ? 10'd1 : line_nxt + 10'd1;
        f         = is_field2(STD_625_IN, next_line);
        v         = is_vblank(STD_625_IN, next_line);
        sav_first = line_words(STD_625_IN) - 11'd4;
        cb0       = STD_625_IN ? CB0_625 : CB0_525;
        first     = first_line(STD_625_IN);
        // Strobe falls with the line strobe of the first line, inside the window
        hs_n_nxt  = !(!emb && pix_nxt < HS_LOW_WORDS);
        vs_n_nxt  = !(!emb && line_nxt >= first && line_nxt < first + VS_LOW_LINES);
        take_nxt  = !is_vblank(STD_625_IN, line_nxt)
                    && (emb ? (pix_nxt < ACTIVE_WORDS) : (pix_nxt >= cb0 && pix_nxt < cb0 + ACTIVE_WORDS));
        data_nxt  = take_nxt ? PIX_DATA_IN : (pix_nxt[0] ? BLANK_Y : BLANK_C);
        if (emb)
        begin
            if (pix_nxt == EAV_FIRST || pix_nxt == sav_first)
                data_nxt = PRE_FF;
            else if (pix_nxt == EAV_CODE)
                data_nxt = trc_word(f, v, 1'b1);
            else if (pix_nxt == sav_first + 11'd3)
                data_nxt = trc_word(f, v, 1'b0);
            else if (pix_nxt > EAV_FIRST && pix_nxt < EAV_CODE)
                data_nxt = PRE_00;
            else if (pix_nxt > sav_first)
                data_nxt = PRE_00;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            pix_r  <= '0;
            line_r <= 10'd1;
            data_r <= BLANK_Y;
            hs_n_r <= 1'b1;
            vs_n_r <= 1'b1;
            take_r <= 1'b0;
        end
        else
        begin
            pix_r  <= pix_nxt;
            line_r <= line_nxt;
            data_r <= data_nxt;
            hs_n_r <= hs_n_nxt;
            vs_n_r <= vs_n_nxt;
            take_r <= take_nxt;
        end
    end

    assign LINK.pixel_data   = data_r;
    assign LINK.line_sync_n  = hs_n_r;
    assign LINK.frame_sync_n = vs_n_r;
    assign PIX_TAKE_OUT      = take_r;
endmodule : video_source
`default_nettype wire

// ===== testbench/sync_recovery_asserts.sv
// Assertion checker on the pixel link and the encoder end's timing outputs
`default_nettype none
module sync_recovery_checker
    import vsync_pkg::*;
(
    input wire logic       SYS_CLK_IN,
    input wire logic       NRST_IN,
    input wire logic [7:0] pixel_data,
    input wire logic       EMBEDDED_SYNC_SELECT_IN,
    input wire logic       STD_625_IN,
    input wire logic       SQUARE_PIXEL_IN,
    input wire logic       EAV_OUT,
    input wire logic       SAV_OUT,
    input wire logic       FIELD2_OUT,
    input wire logic       VBLANK_OUT,
    input wire logic [9:0] LINE_OUT,
    input wire logic       LOCKED_OUT,
    input wire logic       MODE_ERR_OUT,
    input wire logic       OVERFLOW_OUT
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!NRST_IN);

    logic       emb_eff;
    logic       mode_bad;
    logic [7:0] d1_r;
    logic [7:0] d1_nxt;
    logic [7:0] code_r;
    logic [7:0] code_nxt;
    assign emb_eff  = EMBEDDED_SYNC_SELECT_IN && !SQUARE_PIXEL_IN;
    assign mode_bad = EMBEDDED_SYNC_SELECT_IN && SQUARE_PIXEL_IN;

    // Keeps the last timing code so its flags can be compared a cycle later
    always_comb
    begin
        d1_nxt   = pixel_data;
        code_nxt = (EAV_OUT || SAV_OUT) ? d1_r : code_r;
    end
    always_ff @(posedge SYS_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            d1_r   <= 8'h00;
            code_r <= 8'h00;
        end
        else
        begin
            d1_r   <= d1_nxt;
            code_r <= code_nxt;
        end
    end

    sequence preamble_s;
        pixel_data == PRE_FF ##1 pixel_data == PRE_00 ##1 pixel_data == PRE_00;
    endsequence

    a_end_code_pulse: assert property (emb_eff ##0 preamble_s ##1 (emb_eff && pixel_data[7] && pixel_data[4]) |=> EAV_OUT)
        else $error("end code not flagged");
    a_start_code_pulse: assert property (emb_eff ##0 preamble_s ##1 (emb_eff && pixel_data[7] && !pixel_data[4]) |=> SAV_OUT)
        else $error("start code not flagged");
    a_code_history: assert property ((EAV_OUT || SAV_OUT) |-> $past(pixel_data[7]) && $past(pixel_data, 2) == PRE_00
        && $past(pixel_data, 3) == PRE_00 && $past(pixel_data, 4) == PRE_FF)
        else $error("code pulse without full preamble");
    a_code_flags: assert property ((EAV_OUT || SAV_OUT) |=> FIELD2_OUT == code_r[F_BIT] && VBLANK_OUT == code_r[V_BIT])
        else $error("field or blanking flag differs from code");
    a_line_step: assert property (EAV_OUT && LINE_OUT < 10'd200 |-> ##[0:2] (LINE_OUT == $past(LINE_OUT) + 10'd1))
        else $error("line did not step on end code");
    a_mode_error: assert property ($past(NRST_IN) && mode_bad == $past(mode_bad) |-> MODE_ERR_OUT == mode_bad)
        else $error("mode error flag wrong");
    a_strobe_no_codes: assert property (!emb_eff && !$past(emb_eff) && !$past(emb_eff, 2) |-> !EAV_OUT && !SAV_OUT)
        else $error("code pulse in strobe mode");
    a_lock_line: assert property ($rose(LOCKED_OUT) && !EMBEDDED_SYNC_SELECT_IN
        |-> ##[0:2] LINE_OUT == (STD_625_IN ? FIRST_LINE_625 : FIRST_LINE_525))
        else $error("lock not on first line");
    a_line_range: assert property (LINE_OUT >= 10'd1 && LINE_OUT <= (STD_625_IN ? LINES_625 : LINES_525))
        else $error("line number out of range");
    a_lock_holds: assert property ($past(LOCKED_OUT) |-> LOCKED_OUT)
        else $error("lock lost");
    a_blank_lines: assert property (!emb_eff && $stable(LINE_OUT) && LINE_OUT >= 10'd2 && LINE_OUT < ACTIVE_FIRST
        |-> VBLANK_OUT)
        else $error("early line not blanked");

    c_end_code: cover property (EAV_OUT);
    c_lock: cover property ($rose(LOCKED_OUT));
    c_overflow: cover property ($rose(OVERFLOW_OUT));
endmodule : sync_recovery_checker
`default_nettype wire

// ===== testbench/tb_top.sv
// Bench: source and encoder ends face each other; a second encoder gets misplaced strobes
`default_nettype none
module tb_top
    import vsync_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       emb = 1'b0;
    logic       std625 = 1'b0;
    logic       sq = 1'b0;
    logic       rdy = 1'b1;
    logic [7:0] vdata;
    logic [9:0] line;
    logic       vvalid, field2, vblank, eav, sav, locked, mode_err, ovf, bad_locked, take;
    int         err_total = 0;
    int         check_count = 0;
    int         bad_cnt = 0;
    vid_link_if link();
    vid_link_if bad_link();

    always #12.5 clk = ~clk;

    // Frame strobe falls 200 clocks after a line strobe fall: far outside the window
    always @(negedge clk)
    begin
        bad_cnt = (bad_cnt + 1) % (8 * 1716);
        bad_link.line_sync_n = (bad_cnt % 1716) >= 128;
        bad_link.frame_sync_n = !(bad_cnt >= 3 * 1716 + 200 && bad_cnt < 5 * 1716 + 200);
        bad_link.pixel_data = BLANK_Y;
    end

    video_source u_video_source (.SYS_CLK_IN(clk), .NRST_IN(nrst), .LINK(link.source),
        .EMBEDDED_SYNC_SELECT_IN(emb), .STD_625_IN(std625), .SQUARE_PIXEL_IN(sq),
        .PIX_DATA_IN(8'h5a), .PIX_TAKE_OUT(take));
    sync_recovery u_sync_recovery (.SYS_CLK_IN(clk), .NRST_IN(nrst), .LINK(link.encoder),
        .EMBEDDED_SYNC_SELECT_IN(emb), .STD_625_IN(std625), .SQUARE_PIXEL_IN(sq), .VIDEO_READY_IN(rdy),
        .VIDEO_DATA_OUT(vdata), .VIDEO_VALID_OUT(vvalid), .FIELD2_OUT(field2), .VBLANK_OUT(vblank),
        .LINE_OUT(line), .EAV_OUT(eav), .SAV_OUT(sav), .LOCKED_OUT(locked), .MODE_ERR_OUT(mode_err),
        .OVERFLOW_OUT(ovf));
    sync_recovery u_sync_recovery_bad (.SYS_CLK_IN(clk), .NRST_IN(nrst), .LINK(bad_link.encoder),
        .EMBEDDED_SYNC_SELECT_IN(1'b0), .STD_625_IN(1'b0), .SQUARE_PIXEL_IN(1'b0), .VIDEO_READY_IN(1'b1),
        .VIDEO_DATA_OUT(), .VIDEO_VALID_OUT(), .FIELD2_OUT(), .VBLANK_OUT(), .LINE_OUT(), .EAV_OUT(),
        .SAV_OUT(), .LOCKED_OUT(bad_locked), .MODE_ERR_OUT(), .OVERFLOW_OUT());
    sync_recovery_checker u_sync_recovery_checker (.SYS_CLK_IN(clk), .NRST_IN(nrst),
        .pixel_data(link.pixel_data), .EMBEDDED_SYNC_SELECT_IN(emb), .STD_625_IN(std625),
        .SQUARE_PIXEL_IN(sq), .EAV_OUT(eav), .SAV_OUT(sav), .FIELD2_OUT(field2), .VBLANK_OUT(vblank),
        .LINE_OUT(line), .LOCKED_OUT(locked), .MODE_ERR_OUT(mode_err), .OVERFLOW_OUT(ovf));

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask : cycles

    // Waits for lock (sel 1) or for a line number, never longer than bound cycles
    task automatic wait_for(input int sel, input logic [9:0] n, input int bound);
        int i;
        i = 0;
        while ((sel == 1 ? locked !== 1'b1 : line !== n) && i < bound)
        begin
            @(negedge clk);
            i++;
        end
        if (i >= bound)
        begin
            err_total++;
            test_done();
        end
    endtask : wait_for

    // Counts taken, wrong and offered words and code pulses; sampled mid-cycle where all is settled
    // A word shown now is taken at the next rising edge, so look before waiting
    task automatic count(input int n, output logic [15:0] w, output logic [15:0] bd,
                         output logic [15:0] e, output logic [15:0] s, output logic [15:0] t);
        w = 0;
        bd = 0;
        e = 0;
        s = 0;
        t = 0;
        repeat (n)
        begin
            if (vvalid === 1'b1 && rdy)
            begin
                w++;
                if (vdata !== 8'h5a)
                    bd++;
            end
            e += (eav === 1'b1);
            s += (sav === 1'b1);
            t += (take === 1'b1);
            @(negedge clk);
        end
    endtask : count

    task automatic do_reset(input logic e, input logic s);
        nrst = 1'b0;
        emb = e;
        std625 = s;
        sq = 1'b0;
        rdy = 1'b1;
        cycles(3);
        nrst = 1'b1;
    endtask : do_reset

    initial
    begin
        logic [15:0] w, bd, e, s, t;
        do_reset(1'b0, 1'b0);
        wait_for(1, 10'd0, 6 * 1716);
        cycles(3);
        check(line, 16'd4);
        wait_for(0, 10'd22, 20 * 1716);
        check(vblank, 16'd1);
        check(bad_locked, 16'd0);
        wait_for(0, 10'd23, 2 * 1716);
        cycles(2);
        check(vblank, 16'd0);
        count(1716, w, bd, e, s, t);
        check(w, 16'd1440);
        check(t, 16'd1440);
        check(bd, 16'd0);
        rdy = 1'b0;
        cycles(1700);
        check(ovf, 16'd1);
        check(vvalid, 16'd1);
        rdy = 1'b1;
        count(100, w, bd, e, s, t);
        check(w, 16'd33);
        check(vvalid, 16'd0);
        $display("test strobe 525 done");
        do_reset(1'b0, 1'b1);
        wait_for(1, 10'd0, 4 * 1728);
        cycles(3);
        check(line, 16'd1);
        wait_for(0, 10'd23, 30 * 1728);
        cycles(2);
        count(1728, w, bd, e, s, t);
        check(w, 16'd0);
        check(t, 16'd1440);
        count(1728, w, bd, e, s, t);
        check(w, 16'd1440);
        $display("test strobe 625 done");
        do_reset(1'b1, 1'b0);
        count(4 * 1716 - 200, w, bd, e, s, t);
        check(e, 16'd4);
        check(s, 16'd3);
        check(locked, 16'd1);
        check(line, 16'd5);
        check(vblank, 16'd1);
        check(field2, 16'd0);
        sq = 1'b1;
        cycles(3);
        check(mode_err, 16'd1);
        count(1800, w, bd, e, s, t);
        check(e, 16'd0);
        $display("test embedded done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
